// ===== rtl/ips_pkg.sv
// Constants, register map and frame carriers of the ingress policer set.
// Assumes one core clock; all users reference items as ips_pkg::name.
package ips_pkg;
  localparam int          NPOL       = 64;
  localparam int          NDUAL      = 4;
  localparam int          NSTORM     = 8;
  localparam int          NPORTPOL   = 2;
  localparam int          NTYPE      = 6;
  localparam logic [5:0]  PORT_BASE  = 6'h20;
  localparam logic [5:0]  RULE_BASE  = 6'h28;
  localparam logic [5:0]  STORM_BASE = 6'h2C;
  localparam logic [5:0]  FLOOD_BASE = 6'h34;
  localparam logic [5:0]  DUAL_BASE  = 6'h38;
  localparam logic [5:0]  EXC_BASE   = 6'h3C;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_SEL     = 12'h004;
  localparam logic [11:0] REG_RATE    = 12'h008;
  localparam logic [11:0] REG_BURST   = 12'h00C;
  localparam logic [11:0] REG_LEVEL   = 12'h010;
  localparam logic [11:0] REG_MODE    = 12'h014;
  localparam logic [11:0] REG_PTYPE   = 12'h018;
  localparam logic [11:0] REG_STYPE0  = 12'h01C;
  localparam logic [11:0] REG_STYPE1  = 12'h020;
  localparam logic [11:0] REG_TICKDIV = 12'h024;
  localparam logic [11:0] REG_DROPS   = 12'h028;
  // Field positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_AWARE = 1;
  localparam int MODE_BYTE  = 0;
  localparam int MODE_CPL   = 1;
  localparam int LANE_W     = 8;
  // Reset values and per-frame cost
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [15:0] COST_ONE  = 16'h0001;
  // Refill timing
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          REFILL_PERIOD_NS = 1000;
  localparam int          TICK_CYCLES      = REFILL_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] TICKDIV_RST      = 16'(TICK_CYCLES - 1);

  typedef enum logic [1:0] {
    IPS_GREEN  = 2'h0,
    IPS_YELLOW = 2'h1,
    IPS_RED    = 2'h3
  } ips_colour_e;

  // ftype bits: 0 cpu, 1 learn, 2 known uc, 3 unknown uc, 4 mc, 5 bc
  typedef struct packed {
    logic        valid;
    logic [1:0]  port;
    logic [2:0]  qos;
    logic [1:0]  drop_precedence_level;
    logic [5:0]  ftype;
    logic        rule_sr_en;
    logic [1:0]  rule_sr_idx;
    logic        rule_dr_en;
    logic [1:0]  rule_dr_idx;
    logic        flooded;
    logic [7:0]  service_level_contract;
    logic [47:0] dmac;
    logic [13:0] len;
  } ips_frame_s;

  typedef struct packed {
    logic        valid;
    logic        discard;
    logic        dual;
    ips_colour_e colour;
  } ips_result_s;
endpackage : ips_pkg

// ===== rtl/ips_policer_set.sv
// Ingress policer set: per-frame bucket selection, rate check and refill.
// Assumes one descriptor per cycle at most, from the classifier and the
// security_lookup_stage, and an APB master on the same clock.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
module ips_policer_set (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire ips_pkg::ips_frame_s  frame_in,
  output ips_pkg::ips_result_s      result_out
);
  logic [15:0]               level_reg [ips_pkg::NPOL];
  logic [15:0]               level_next[ips_pkg::NPOL];
  logic [7:0]                rate_reg  [ips_pkg::NPOL];
  logic [15:0]               burst_reg [ips_pkg::NPOL];
  logic [1:0]                mode_reg  [ips_pkg::NPOL];
  logic [5:0]                ptype_reg [ips_pkg::NPORTPOL];
  logic [5:0]                stype_reg [ips_pkg::NSTORM];
  logic [1:0]                ctrl_reg;
  logic [5:0]                sel_reg;
  logic [15:0]               tickdiv_reg;
  logic [15:0]               tick_cnt_reg;
  logic [31:0]               drops_reg;
  logic [31:0]               prdata_reg;
  logic                      pready_reg;
  logic                      pslverr_reg;
  ips_pkg::ips_result_s      res_reg;
  ips_pkg::ips_result_s      res_next;
  logic [ips_pkg::NPOL-1:0]  trig;
  logic [ips_pkg::NPOL-1:0]  ok;
  logic [ips_pkg::NPOL-1:0]  chg;
  logic [31:0]               rd_data;
  logic                      rd_hit;

  function automatic logic [5:0] ips_idx(input logic [5:0] base, input logic [5:0] off);
    ips_idx = base + off;
  endfunction : ips_idx

  function automatic logic [1:0] ips_fold2(input logic [55:0] v);
    logic [1:0] f;
    f = 2'h0;
    for (int k = 0; k < 28; k++) begin
      f = f ^ v[2*k +: 2];
    end
    ips_fold2 = f;
  endfunction : ips_fold2

  function automatic logic [15:0] ips_cost(input logic byte_mode, input logic [13:0] len);
    ips_cost = byte_mode ? {2'h0, len} : ips_pkg::COST_ONE;
  endfunction : ips_cost

  // APB decode
  wire setup    = psel & ~penable;
  wire wr_en    = psel & penable & pwrite & pready_reg;
  wire wr_ctrl  = wr_en & (paddr == ips_pkg::REG_CTRL);
  wire wr_sel   = wr_en & (paddr == ips_pkg::REG_SEL);
  wire wr_rate  = wr_en & (paddr == ips_pkg::REG_RATE);
  wire wr_burst = wr_en & (paddr == ips_pkg::REG_BURST);
  wire wr_mode  = wr_en & (paddr == ips_pkg::REG_MODE);
  wire wr_ptype = wr_en & (paddr == ips_pkg::REG_PTYPE);
  wire wr_st0   = wr_en & (paddr == ips_pkg::REG_STYPE0);
  wire wr_st1   = wr_en & (paddr == ips_pkg::REG_STYPE1);
  wire wr_tdiv  = wr_en & (paddr == ips_pkg::REG_TICKDIV);

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (paddr == ips_pkg::REG_CTRL) begin
      rd_data = {30'h0, ctrl_reg};
    end else if (paddr == ips_pkg::REG_SEL) begin
      rd_data = {26'h0, sel_reg};
    end else if (paddr == ips_pkg::REG_RATE) begin
      rd_data = {24'h0, rate_reg[sel_reg]};
    end else if (paddr == ips_pkg::REG_BURST) begin
      rd_data = {16'h0, burst_reg[sel_reg]};
    end else if (paddr == ips_pkg::REG_LEVEL) begin
      rd_data = {16'h0, level_reg[sel_reg]};
    end else if (paddr == ips_pkg::REG_MODE) begin
      rd_data = {30'h0, mode_reg[sel_reg]};
    end else if (paddr == ips_pkg::REG_PTYPE) begin
      rd_data = {18'h0, ptype_reg[1], 2'h0, ptype_reg[0]};
    end else if (paddr == ips_pkg::REG_STYPE0) begin
      rd_data = {2'h0, stype_reg[3], 2'h0, stype_reg[2], 2'h0, stype_reg[1], 2'h0, stype_reg[0]};
    end else if (paddr == ips_pkg::REG_STYPE1) begin
      rd_data = {2'h0, stype_reg[7], 2'h0, stype_reg[6], 2'h0, stype_reg[5], 2'h0, stype_reg[4]};
    end else if (paddr == ips_pkg::REG_TICKDIV) begin
      rd_data = {16'h0, tickdiv_reg};
    end else if (paddr == ips_pkg::REG_DROPS) begin
      rd_data = drops_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Zero-wait slave: answer staged in setup, shown in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~rd_hit;
      prdata_reg  <= (setup & ~pwrite & rd_hit) ? rd_data : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= ips_pkg::CTRL_RST;
      sel_reg     <= 6'h00;
      tickdiv_reg <= ips_pkg::TICKDIV_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= pwdata[1:0];
      if (wr_sel) sel_reg <= pwdata[5:0];
      if (wr_tdiv) tickdiv_reg <= pwdata[15:0];
    end
  end

  // Traffic type masks of port and storm slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < ips_pkg::NPORTPOL; k++) ptype_reg[k] <= 6'h00;
      for (int k = 0; k < ips_pkg::NSTORM; k++) stype_reg[k] <= 6'h00;
    end else begin
      for (int k = 0; k < ips_pkg::NPORTPOL; k++) begin
        if (wr_ptype) ptype_reg[k] <= pwdata[k*ips_pkg::LANE_W +: ips_pkg::NTYPE];
      end
      for (int k = 0; k < ips_pkg::NSTORM / 2; k++) begin
        if (wr_st0) stype_reg[k] <= pwdata[k*ips_pkg::LANE_W +: ips_pkg::NTYPE];
        if (wr_st1) stype_reg[k+4] <= pwdata[k*ips_pkg::LANE_W +: ips_pkg::NTYPE];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ips_pkg::NPOL; i++) begin
        rate_reg[i]  <= 8'h00;
        burst_reg[i] <= 16'h0000;
        mode_reg[i]  <= 2'h0;
      end
    end else begin
      if (wr_rate) rate_reg[sel_reg] <= pwdata[7:0];
      if (wr_burst) burst_reg[sel_reg] <= pwdata[15:0];
      if (wr_mode) mode_reg[sel_reg] <= pwdata[1:0];
    end
  end

  // Bucket selection
  wire       pol_en      = ctrl_reg[ips_pkg::CTRL_EN];
  wire       act         = frame_in.valid & pol_en;
  wire [5:0] prio_idx    = {1'b0, frame_in.port, frame_in.qos};
  wire [5:0] rule_idx    = ips_idx(ips_pkg::RULE_BASE, {4'h0, frame_in.rule_sr_idx});
  wire [5:0] dual_idx    = ips_idx(ips_pkg::DUAL_BASE, {4'h0, frame_in.rule_dr_idx});
  wire [5:0] exc_idx     = ips_idx(ips_pkg::EXC_BASE, {4'h0, frame_in.rule_dr_idx});
  wire [1:0] flood_hash  = ips_fold2({frame_in.service_level_contract, frame_in.dmac});
  wire [5:0] flood_idx   = ips_idx(ips_pkg::FLOOD_BASE, {4'h0, flood_hash});
  wire [ips_pkg::NPOL-1:0] dual_mask = {{(ips_pkg::NPOL-ips_pkg::NDUAL){1'b0}},
                                        {ips_pkg::NDUAL{1'b1}}} << ips_pkg::DUAL_BASE;
  wire [ips_pkg::NPOL-1:0] exc_mask  = {{(ips_pkg::NPOL-ips_pkg::NDUAL){1'b0}},
                                        {ips_pkg::NDUAL{1'b1}}} << ips_pkg::EXC_BASE;

  always_comb begin
    trig = '0;
    if (act) begin
      if (frame_in.rule_dr_en) begin
        trig[dual_idx] = 1'b1;
      end else begin
        trig[prio_idx] = 1'b1;
      end
      if (frame_in.rule_sr_en) trig[rule_idx] = 1'b1;
      if (frame_in.flooded) trig[flood_idx] = 1'b1;
      for (int k = 0; k < ips_pkg::NPORTPOL; k++) begin
        trig[ips_idx(ips_pkg::PORT_BASE, {3'h0, frame_in.port, k[0]})] =
          |(ptype_reg[k] & frame_in.ftype);
      end
      for (int k = 0; k < ips_pkg::NSTORM; k++) begin
        trig[ips_idx(ips_pkg::STORM_BASE, 6'(k))] = |(stype_reg[k] & frame_in.ftype);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < ips_pkg::NPOL; i++) begin
      ok[i] = level_reg[i] >= ips_cost(mode_reg[i][ips_pkg::MODE_BYTE], frame_in.len);
    end
  end

  // Colouring and verdict
  wire sr_fail    = |(trig & ~dual_mask & ~ok);
  wire dual_act   = act & frame_in.rule_dr_en;
  wire aware      = ctrl_reg[ips_pkg::CTRL_AWARE];
  wire pre_yellow = aware & (frame_in.drop_precedence_level != 2'h0);
  wire c_ok       = ok[dual_idx];
  wire e_ok       = ok[exc_idx];
  ips_pkg::ips_colour_e colour;
  assign colour = (~pre_yellow & c_ok) ? ips_pkg::IPS_GREEN :
                  e_ok ? ips_pkg::IPS_YELLOW : ips_pkg::IPS_RED;
  wire red_drop   = dual_act & (colour == ips_pkg::IPS_RED);
  wire discard    = act & (sr_fail | red_drop);
  wire pass       = act & ~discard;

  always_comb begin
    chg = pass ? (trig & ~dual_mask) : '0;
    if (pass & dual_act) begin
      if (colour == ips_pkg::IPS_GREEN) chg[dual_idx] = 1'b1;
      else chg[exc_idx] = 1'b1;
    end
  end

  always_comb begin
    res_next         = '0;
    res_next.valid   = frame_in.valid;
    res_next.discard = discard;
    res_next.dual    = dual_act;
    res_next.colour  = dual_act ? colour : ips_pkg::IPS_GREEN;
  end

  // Refill and charge; coupled excess buckets also gain the committed rate when committed overflows
  // Compare, not match, so a smaller divider takes effect at once
  wire tick = (tick_cnt_reg >= tickdiv_reg);
  logic [16:0] sum;
  logic [15:0] left;
  logic [ips_pkg::NDUAL-1:0] c_over;
  always_comb begin
    sum    = 17'h0_0000;
    left   = 16'h0000;
    c_over = '0;
    for (int i = 0; i < ips_pkg::NPOL; i++) begin
      left = level_reg[i] - (chg[i] ? ips_cost(mode_reg[i][ips_pkg::MODE_BYTE], frame_in.len)
                                    : 16'h0000);
      sum  = {1'b0, left} + (tick ? {9'h000, rate_reg[i]} : 17'h0_0000);
      // Six-bit wrap keeps every unrolled index in range
      if (dual_mask[i]) begin
        c_over[2'(6'(i) - ips_pkg::DUAL_BASE)] = tick & (sum > {1'b0, burst_reg[i]});
      end
      if (exc_mask[i] && mode_reg[6'(i) - 6'(ips_pkg::NDUAL)][ips_pkg::MODE_CPL] &&
          c_over[2'(6'(i) - ips_pkg::EXC_BASE)]) begin
        sum = sum + {9'h000, rate_reg[6'(i) - 6'(ips_pkg::NDUAL)]};
      end
      level_next[i] = (sum > {1'b0, burst_reg[i]}) ? burst_reg[i] : sum[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ips_pkg::NPOL; i++) level_reg[i] <= 16'h0000;
      tick_cnt_reg <= 16'h0000;
      drops_reg    <= 32'h0000_0000;
      res_reg      <= '0;
    end else begin
      for (int i = 0; i < ips_pkg::NPOL; i++) level_reg[i] <= level_next[i];
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
      if (discard) drops_reg <= drops_reg + 32'h0000_0001;
      res_reg <= res_next;
    end
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign result_out = res_reg;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PRIO_SEL: assert property (act & ~frame_in.rule_dr_en |-> trig[prio_idx])
    else $error("priority policer not selected");
  AST_PORT_SEL: assert property (act |-> trig[ips_idx(ips_pkg::PORT_BASE,
      {3'h0, frame_in.port, 1'b0})] == |(ptype_reg[0] & frame_in.ftype))
    else $error("port policer selection wrong");
  AST_RULE_SEL: assert property (act & frame_in.rule_sr_en |-> trig[rule_idx])
    else $error("rule policer not selected");
  AST_ONE_OF: assert property (act |-> $onehot0({|trig[31:0], |(trig & dual_mask)}))
    else $error("priority and dual-rate both applied");
  AST_STORM_SEL: assert property (act |-> trig[ips_pkg::STORM_BASE +: ips_pkg::NSTORM] == 0
      || |frame_in.ftype)
    else $error("storm policer without frame type");
  AST_FLOOD_SEL: assert property (act & ~frame_in.flooded
      |-> trig[ips_pkg::FLOOD_BASE +: ips_pkg::NDUAL] == 0)
    else $error("flood policer on non-flooded frame");
  AST_AWARE: assert property (dual_act & aware & (frame_in.drop_precedence_level != 2'h0)
      |=> result_out.colour != ips_pkg::IPS_GREEN)
    else $error("aware mode coloured pre-yellow frame green");
  AST_BLIND_GREEN: assert property (dual_act & ~aware & c_ok
      |=> result_out.colour == ips_pkg::IPS_GREEN)
    else $error("committed frame not green");
  AST_RED_DROP: assert property (result_out.valid & result_out.dual
      & (result_out.colour == ips_pkg::IPS_RED) |-> result_out.discard)
    else $error("red frame passed");
  AST_SR_DROP: assert property (act & frame_in.rule_sr_en
      & mode_reg[rule_idx][ips_pkg::MODE_BYTE] & (level_reg[rule_idx] < {2'h0, frame_in.len})
      |=> result_out.discard)
    else $error("byte bucket overdraw passed");
  AST_EXHAUST: assert property (act & sr_fail |=> result_out.valid && result_out.discard)
    else $error("exhausted bucket passed frame");
  AST_BURST_CAP: assert property ($stable(sel_reg) && $stable(burst_reg[sel_reg])
      |-> level_reg[sel_reg] <= burst_reg[sel_reg])
    else $error("bucket above burst");
  AST_DUAL_SEL: assert property (dual_act |-> trig[dual_idx] && !trig[prio_idx])
    else $error("dual-rate policer not selected");
  AST_STORM_MASK: assert property (act |-> trig[ips_idx(ips_pkg::STORM_BASE, 6'h00)]
      == |(stype_reg[0] & frame_in.ftype))
    else $error("storm mask not applied");
  AST_DISABLED: assert property (frame_in.valid & ~pol_en
      |=> result_out.valid && !result_out.discard && !result_out.dual)
    else $error("disabled policing touched a frame");
  AST_YELLOW_CHG: assert property (pass & dual_act & (colour == ips_pkg::IPS_YELLOW)
      |-> chg[exc_idx] && !chg[dual_idx])
    else $error("yellow frame charged wrong bucket");
  AST_APB_READY: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  COV_GREEN: cover property (result_out.valid & result_out.dual
      & (result_out.colour == ips_pkg::IPS_GREEN));
  COV_YELLOW: cover property (result_out.valid & (result_out.colour == ips_pkg::IPS_YELLOW)
      & !result_out.discard);
  COV_DROP: cover property (result_out.valid & result_out.discard);
  COV_AWARE: cover property (dual_act & pre_yellow & e_ok);
  COV_WRITE: cover property (wr_burst ##[1:20] (level_reg[sel_reg] != 16'h0000));
endmodule : ips_policer_set

// ===== tb/ips_frame_src.sv
// Upstream classifier stand-in: registers one descriptor per cycle.
// Assumes the bench raises go with a descriptor just after a clock edge.
`timescale 1ns/10ps
module ips_frame_src (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                go,
  input  wire ips_pkg::ips_frame_s desc,
  output ips_pkg::ips_frame_s      frame_out
);
  // Idle cycles clear valid and toggle the other fields, so a stale descriptor can never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      frame_out <= '0;
    else if (go)
      frame_out <= desc;
    else
      frame_out <= {1'b0, ~frame_out[$bits(frame_out)-2:0]};
  end
endmodule : ips_frame_src

// ===== tb/ips_policer_set_tb.sv
// Self-checking bench of the policer set: APB setup, frames, scoreboard.
// Assumes zero-wait APB slave and a result two edges after the descriptor.
`timescale 1ns/10ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin failures++; \
  $display("BAD %s expected %h seen %h", nm, e, s); end end
module ips_policer_set_tb;
  localparam logic [3:0] PASS = 4'h0;
  localparam logic [3:0] DROP = 4'h8;
  localparam logic [3:0] DG   = 4'h4;
  localparam logic [3:0] DY   = 4'h5;
  localparam logic [3:0] DR   = 4'hF;
  logic                 pclk = 1'b0;
  logic                 presetn = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic                 go = 1'b0;
  logic [11:0]          paddr = 12'h0;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  ips_pkg::ips_frame_s  desc = '0;
  ips_pkg::ips_frame_s  frame_in;
  ips_pkg::ips_frame_s  f;
  ips_pkg::ips_result_s result_out;
  logic [3:0]           expq[$];
  logic [3:0]           tbl[6];
  int                   failures = 0;
  int                   num_checks = 0;

  always #25 pclk = ~pclk;

  ips_frame_src src (.pclk(pclk), .presetn(presetn), .go(go), .desc(desc),
                     .frame_out(frame_in));
  ips_policer_set uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
                       .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                       .pready(pready), .pslverr(pslverr), .frame_in(frame_in),
                       .result_out(result_out));

  always @(posedge pclk) begin
    logic [3:0] e_v;
    if (result_out.valid === 1'b1) begin
      e_v = (expq.size() == 0) ? 4'h2 : expq.pop_front();
      `CHK("result", e_v, {result_out.discard, result_out.dual, result_out.colour})
    end
  end

  task report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic ee);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK("prdata", ed, r)
    `CHK("pslverr", ee, e)
  endtask : rd

  // Fill at rate r0, then hold at rate r1; an r1 of 0 freezes the level for exact counts
  task automatic cfg(input logic [5:0] idx, input logic md, input logic [15:0] b,
                     input logic [7:0] r0, input logic [7:0] r1);
    wr(ips_pkg::REG_SEL, 32'(idx));
    wr(ips_pkg::REG_MODE, 32'(md));
    wr(ips_pkg::REG_BURST, 32'(b));
    wr(ips_pkg::REG_RATE, 32'(r0));
    wr(ips_pkg::REG_RATE, 32'(r1));
  endtask : cfg

  task automatic send(input ips_pkg::ips_frame_s x, input logic [3:0] e);
    @(posedge pclk);
    go <= 1'b1;
    desc <= x;
    expq.push_back(e);
  endtask : send

  task automatic halt(input string nm);
    int n;
    @(posedge pclk);
    go <= 1'b0;
    for (n = 0; n < 20 && expq.size() != 0; n++)
      @(posedge pclk);
    if (expq.size() != 0) begin
      failures++;
      report_and_stop();
    end
    $display("test %s done", nm);
  endtask : halt

  function automatic logic [1:0] fold(input logic [55:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 28; i++)
      r ^= v[2*i +: 2];
    return r;
  endfunction : fold

  initial begin
    void'($urandom(82));
    f = '0;
    f.valid = 1'b1;
    f.port = 2'h1;
    f.qos = 3'h3;
    f.ftype = 6'h04;
    f.service_level_contract = 8'($urandom);
    f.dmac = {16'($urandom), 32'($urandom)};
    f.len = 14'(64 + $urandom % 1455);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(ips_pkg::REG_CTRL, 32'h0, 1'b0);
    rd(ips_pkg::REG_TICKDIV, 32'h13, 1'b0);
    rd(12'h100, 32'h0, 1'b1);
    wr(ips_pkg::REG_LEVEL, 32'hFF);
    rd(ips_pkg::REG_LEVEL, 32'h0, 1'b0);
    send(f, PASS);
    halt("regs");
    wr(ips_pkg::REG_TICKDIV, 32'h0);
    cfg(6'h0B, 1'b0, 16'hFFFF, 8'hFF, 8'hFF);
    wr(ips_pkg::REG_CTRL, 32'h1);
    send(f, PASS);
    f.qos = 3'h4;
    send(f, DROP);
    f.qos = 3'h3;
    f.port = 2'h2;
    send(f, DROP);
    f.port = 2'h1;
    halt("priority");
    cfg(6'h28, 1'b0, 16'h2, 8'h2, 8'h0);
    f.rule_sr_en = 1'b1;
    send(f, PASS);
    send(f, PASS);
    send(f, DROP);
    halt("rule frames");
    rd(ips_pkg::REG_LEVEL, 32'h0, 1'b0);
    rd(ips_pkg::REG_DROPS, 32'h3, 1'b0);
    cfg(6'h29, 1'b1, 16'h64, 8'h64, 8'h0);
    f.rule_sr_idx = 2'h1;
    f.len = 14'h3C;
    send(f, PASS);
    send(f, DROP);
    f.len = 14'h28;
    send(f, PASS);
    halt("rule bytes");
    rd(ips_pkg::REG_LEVEL, 32'h0, 1'b0);
    f.rule_sr_en = 1'b0;
    f.rule_dr_en = 1'b1;
    // Same drop precedence pattern, blind then aware
    tbl = '{DG, DY, DR, DY, DG, DR};
    for (int m = 0; m < 2; m++) begin
      wr(ips_pkg::REG_CTRL, 32'(1 + 2 * m));
      cfg(6'h38, 1'b0, 16'h1, 8'h1, 8'h0);
      cfg(6'h3C, 1'b0, 16'h1, 8'h1, 8'h0);
      for (int k = 0; k < 3; k++) begin
        f.drop_precedence_level = (k == 1) ? 2'h0 : 2'h1;
        send(f, tbl[3*m+k]);
      end
      halt("dual");
    end
    // Excess bucket has no rate of its own; only coupling can fill it
    cfg(6'h3C, 1'b0, 16'h2, 8'h0, 8'h0);
    cfg(6'h38, 1'b0, 16'h1, 8'h1, 8'h1);
    wr(ips_pkg::REG_SEL, 32'h3C);
    rd(ips_pkg::REG_LEVEL, 32'h0, 1'b0);
    wr(ips_pkg::REG_SEL, 32'h38);
    wr(ips_pkg::REG_MODE, 32'h2);
    wr(ips_pkg::REG_SEL, 32'h3C);
    rd(ips_pkg::REG_LEVEL, 32'h2, 1'b0);
    $display("test coupling done");
    f.rule_dr_en = 1'b0;
    f.drop_precedence_level = 2'h0;
    wr(ips_pkg::REG_CTRL, 32'h1);
    wr(ips_pkg::REG_STYPE0, 32'h20);
    wr(ips_pkg::REG_PTYPE, 32'h10);
    for (int k = 0; k < 6; k++) begin
      f.ftype = 6'(1 << k);
      f.len = 14'(64 + $urandom % 1455);
      send(f, (k >= 4) ? DROP : PASS);
    end
    halt("types");
    f.ftype = 6'h04;
    f.flooded = 1'b1;
    cfg(6'(ips_pkg::FLOOD_BASE + fold({f.service_level_contract, f.dmac})),
        1'b0, 16'hA, 8'hA, 8'h0);
    send(f, PASS);
    f.service_level_contract[0] = ~f.service_level_contract[0];
    send(f, DROP);
    halt("flood");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ips_pkg::REG_DROPS, 32'h0, 1'b0);
    rd(ips_pkg::REG_TICKDIV, 32'h13, 1'b0);
    rd(ips_pkg::REG_CTRL, 32'h0, 1'b0);
    $display("test reset done");
    report_and_stop();
  end
endmodule : ips_policer_set_tb
